//--- pbcd_pkg.sv
// Shared constants and types for the packet and block copy engine
package pbcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special function register offsets
  localparam logic [7:0] SFR_STATUS = 8'h94;
  localparam logic [7:0] SFR_BUS_ARB = 8'h9a;
  localparam logic [7:0] SFR_INDEX = 8'h9b;
  localparam logic [7:0] SFR_DATA = 8'h9c;

  ////////////////////////////////////////////////////////////////////////////
  // Indirect register indices
  localparam logic [7:0] IDX_CMD = 8'h00;
  localparam logic [7:0] IDX_SRC = 8'h02;
  localparam logic [7:0] IDX_TGT = 8'h06;
  localparam logic [7:0] IDX_CNT = 8'h0a;
  localparam logic [7:0] IDX_MAX = 8'h0f;
  localparam logic [7:0] IDX_ABORT = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CMD_GO = 0;
  localparam int CMD_FS = 1;
  localparam int CMD_ERR = 2;
  localparam int CMD_SAIR = 4;
  localparam int CMD_TAIT = 5;
  localparam int CMD_EI = 7;
  localparam int BUS_REQ_BIT = 0;
  localparam int BUS_GRANT_BIT = 7;
  localparam int STAT_DONE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and transfer sizes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_ADDR = 24'h000000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [8:0] PKT_CHUNK = 9'h100;
  localparam logic [8:0] COPY_CHUNK = 9'h080;
  localparam logic [3:0] STRETCH_EXTRA = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Engine states and channels
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_GRANT, ST_READ, ST_WRITE, ST_GAP
  } pbcd_state_t;

  typedef enum logic [1:0] {CH_RX, CH_TX, CH_COPY} pbcd_chan_t;

endpackage : pbcd_pkg

//--- pbcd_mem_cycle.sv
// Stretched byte cycle timer for external data memory accesses
`timescale 1ns/100ps
`default_nettype none
module pbcd_mem_cycle (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request side
  input wire logic cyc_req,
  input wire logic cyc_write,
  input wire logic [2:0] stretch,
  output logic cyc_done,
  // Memory strobes
  output logic mem_we,
  output logic mem_re
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] last;

  // Byte length is stretch plus the fixed extra cycles
  assign last = {1'b0, stretch} + pbcd_pkg::STRETCH_EXTRA - 4'h1;
  assign cyc_done = cyc_req && (cnt_r == last);
  assign mem_we = cyc_req && cyc_write;
  assign mem_re = cyc_req && !cyc_write;

  // Cycle counter runs while the request holds
  always_comb begin
    cnt_nxt = 4'h0;
    if (cyc_req && !cyc_done) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : pbcd_mem_cycle
`default_nettype wire

//--- pbcd_engine.sv
// Packet and block copy DMA engine with indirect register access
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Receive request raises the second interrupt line, waits for grant.
// - Receive bytes are written into the receive ring as memory writes.
// - Transmit request raises the interrupt, waits grant, then reads the ring.
// - Packet transfers are split into pieces of at most 256 bytes.
// - Idle gap between pieces follows the transfer gap register value.
// - Each memory byte takes stretch field plus two clock cycles.
// - Block copy moves a software range of memory to another range.
// - Block copies are split into pieces of at most 128 bytes.
// - Ring-flagged copy source or target wraps at the ring boundary.
// - Other copies step source and target linearly by one per byte.
// - Index register selects indirect registers; all-ones aborts the command.
// - Data register passes bytes to and from the selected indirect register.
// - Status bit 0 reads 1 after a finished copy, cleared by reading.
// - Data bytes are pushed low byte first; the index write commits them.
// - Start bit launches copy, stays set until done or stopped; zero ignored.
// - Zero count, equal or overlapping ranges flag an error, copy not run.
// - Software grants the bus with bit 7; hardware clears it at completion.
module pbcd_engine (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Special function register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Settings owned by other units
  input wire logic [2:0] clock_stretch_control,
  input wire logic [7:0] transfer_gap_register,
  input wire logic [23:0] rx_ring_first,
  input wire logic [23:0] rx_ring_last,
  input wire logic [23:0] tx_ring_first,
  input wire logic [23:0] tx_ring_last,
  // Offload engine receive side
  input wire logic rx_req,
  input wire logic [23:0] rx_addr,
  input wire logic [15:0] rx_len,
  input wire logic [7:0] rx_data,
  output logic rx_ack,
  output logic rx_take,
  output logic rx_done,
  // Offload engine transmit side
  input wire logic tx_req,
  input wire logic [23:0] tx_addr,
  input wire logic [15:0] tx_len,
  output logic tx_ack,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_done,
  // Interrupt to the processor
  output logic second_external_interrupt,
  // External data memory
  output logic [23:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic in_ring(input logic [23:0] a, input logic [23:0] lo,
                                   input logic [23:0] hi);
    in_ring = (a >= lo) && (a <= hi);
  endfunction : in_ring

  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic wrap,
                                            input logic [23:0] lo, input logic [23:0] hi);
    step_addr = (wrap && a == hi) ? lo : a + 24'h000001;
  endfunction : step_addr

  ////////////////////////////////////////////////////////////////////////////
  // State
  pbcd_pkg::pbcd_state_t state_r, state_nxt;
  pbcd_pkg::pbcd_chan_t chan_r, chan_nxt;
  logic [23:0] src_r, src_nxt, tgt_r, tgt_nxt;
  logic [15:0] left_r, left_nxt;
  logic [8:0] chunk_r, chunk_nxt;
  logic [7:0] gap_r, gap_nxt, byte_r, byte_nxt;
  logic grant_r, grant_nxt, done_r, done_nxt;
  logic go_r, go_nxt, fs_r, fs_nxt, err_r, err_nxt;
  logic sair_r, sair_nxt, tait_r, tait_nxt, ei_r, ei_nxt;
  logic [23:0] reg_src_r, reg_src_nxt, reg_tgt_r, reg_tgt_nxt, stage_r, stage_nxt;
  logic [15:0] reg_cnt_r, reg_cnt_nxt;
  logic [7:0] index_r, index_nxt, rdata_r, rdata_nxt, tx_data_r, tx_data_nxt;
  logic [1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic cyc_done, byte_end, stop, finish;
  logic [24:0] s_lo, t_lo, n_len;
  logic copy_bad;
  logic [23:0] sel_val;
  logic [7:0] cmd_byte;
  logic [8:0] limit;
  logic wrap_src, wrap_tgt;
  logic [23:0] src_lo, src_hi, tgt_lo, tgt_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Byte cycle timer
  pbcd_mem_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst(rst),
    .cyc_req(state_r == pbcd_pkg::ST_READ || state_r == pbcd_pkg::ST_WRITE),
    .cyc_write(state_r == pbcd_pkg::ST_WRITE),
    .stretch(clock_stretch_control),
    .cyc_done(cyc_done),
    .mem_we(mem_we),
    .mem_re(mem_re)
  );

  // Memory address and data paths
  assign mem_addr = (state_r == pbcd_pkg::ST_WRITE) ? tgt_r : src_r;
  assign mem_wdata = (chan_r == pbcd_pkg::CH_RX) ? rx_data : byte_r;
  assign second_external_interrupt = (state_r != pbcd_pkg::ST_IDLE);
  assign sfr_rdata = rdata_r;
  assign tx_data = tx_data_r;
  assign tx_valid = tx_valid_r;

  // Ring selection per channel
  assign src_lo = (chan_r == pbcd_pkg::CH_TX) ? tx_ring_first : rx_ring_first;
  assign src_hi = (chan_r == pbcd_pkg::CH_TX) ? tx_ring_last : rx_ring_last;
  assign tgt_lo = (chan_r == pbcd_pkg::CH_RX) ? rx_ring_first : tx_ring_first;
  assign tgt_hi = (chan_r == pbcd_pkg::CH_RX) ? rx_ring_last : tx_ring_last;
  assign wrap_src = (chan_r == pbcd_pkg::CH_TX) || (chan_r == pbcd_pkg::CH_COPY && sair_r);
  assign wrap_tgt = (chan_r == pbcd_pkg::CH_RX) || (chan_r == pbcd_pkg::CH_COPY && tait_r);
  assign limit = (chan_r == pbcd_pkg::CH_COPY) ? pbcd_pkg::COPY_CHUNK : pbcd_pkg::PKT_CHUNK;

  // Copy parameter checks
  assign s_lo = {1'b0, reg_src_r};
  assign t_lo = {1'b0, reg_tgt_r};
  assign n_len = {9'h000, reg_cnt_r};
  assign copy_bad = (reg_cnt_r == pbcd_pkg::RST_CNT) || (s_lo < t_lo + n_len && t_lo < s_lo + n_len)
                    || (sair_r && !in_ring(reg_src_r, rx_ring_first, rx_ring_last))
                    || (tait_r && !in_ring(reg_tgt_r, tx_ring_first, tx_ring_last));

  // Indirect read view
  assign cmd_byte = {ei_r, 1'b0, tait_r, sair_r, 1'b0, err_r, fs_r, go_r};
  always_comb begin
    case (index_r)
      pbcd_pkg::IDX_CMD: sel_val = {16'h0000, cmd_byte};
      pbcd_pkg::IDX_SRC: sel_val = reg_src_r;
      pbcd_pkg::IDX_TGT: sel_val = reg_tgt_r;
      pbcd_pkg::IDX_CNT: sel_val = {8'h00, reg_cnt_r};
      default: sel_val = pbcd_pkg::RST_ADDR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access and transfer sequencing
  always_comb begin
    state_nxt = state_r; chan_nxt = chan_r; src_nxt = src_r; tgt_nxt = tgt_r;
    left_nxt = left_r; chunk_nxt = chunk_r; gap_nxt = gap_r; byte_nxt = byte_r;
    grant_nxt = grant_r; done_nxt = done_r; go_nxt = go_r; fs_nxt = fs_r;
    err_nxt = err_r; sair_nxt = sair_r; tait_nxt = tait_r; ei_nxt = ei_r;
    reg_src_nxt = reg_src_r; reg_tgt_nxt = reg_tgt_r; reg_cnt_nxt = reg_cnt_r;
    stage_nxt = stage_r; index_nxt = index_r; wptr_nxt = wptr_r; rptr_nxt = rptr_r;
    rdata_nxt = rdata_r; tx_data_nxt = tx_data_r; tx_valid_nxt = 1'b0;
    rx_ack = 1'b0; tx_ack = 1'b0; rx_take = 1'b0; rx_done = 1'b0; tx_done = 1'b0;
    byte_end = 1'b0; stop = 1'b0; finish = 1'b0;
    // Processor reads; clear-on-read comes before hardware sets
    if (sfr_rd) begin
      case (sfr_addr)
        pbcd_pkg::SFR_STATUS: begin
          rdata_nxt = {7'h00, done_r};
          done_nxt = 1'b0;
        end
        pbcd_pkg::SFR_BUS_ARB: rdata_nxt = {grant_r, 6'h00, state_r != pbcd_pkg::ST_IDLE};
        pbcd_pkg::SFR_DATA: begin
          rdata_nxt = sel_val[rptr_r*8 +: 8];
          if (rptr_r != 2'h2) rptr_nxt = rptr_r + 2'h1;
          if (index_r == pbcd_pkg::IDX_CMD) err_nxt = 1'b0;
        end
        default: rdata_nxt = pbcd_pkg::RST_BYTE;
      endcase
    end
    // Processor writes
    if (sfr_wr) begin
      case (sfr_addr)
        pbcd_pkg::SFR_DATA: begin
          stage_nxt[wptr_r*8 +: 8] = sfr_wdata;
          if (wptr_r != 2'h2) wptr_nxt = wptr_r + 2'h1;
        end
        pbcd_pkg::SFR_BUS_ARB: begin
          if (sfr_wdata[pbcd_pkg::BUS_GRANT_BIT] && state_r != pbcd_pkg::ST_IDLE) begin
            grant_nxt = 1'b1;
          end
        end
        pbcd_pkg::SFR_INDEX: begin
          wptr_nxt = 2'h0;
          rptr_nxt = 2'h0;
          if (sfr_wdata == pbcd_pkg::IDX_ABORT) begin
            fs_nxt = go_r;
          end else if (sfr_wdata <= pbcd_pkg::IDX_MAX) begin
            index_nxt = sfr_wdata;
            case (sfr_wdata)
              pbcd_pkg::IDX_SRC: reg_src_nxt = stage_r;
              pbcd_pkg::IDX_TGT: reg_tgt_nxt = stage_r;
              pbcd_pkg::IDX_CNT: reg_cnt_nxt = stage_r[15:0];
              pbcd_pkg::IDX_CMD: begin
                ei_nxt = stage_r[pbcd_pkg::CMD_EI];
                if (stage_r[pbcd_pkg::CMD_GO] && !go_r) begin
                  go_nxt = 1'b1;
                  sair_nxt = stage_r[pbcd_pkg::CMD_SAIR];
                  tait_nxt = stage_r[pbcd_pkg::CMD_TAIT];
                end
                if (stage_r[pbcd_pkg::CMD_FS] && go_r) fs_nxt = 1'b1;
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
    // Transfer sequencing
    case (state_r)
      pbcd_pkg::ST_IDLE: begin
        chunk_nxt = 9'h000;
        if (rx_req) begin
          rx_ack = 1'b1;
          chan_nxt = pbcd_pkg::CH_RX;
          tgt_nxt = rx_addr;
          left_nxt = rx_len;
          if (rx_len != pbcd_pkg::RST_CNT) state_nxt = pbcd_pkg::ST_WAIT_GRANT;
        end else if (tx_req) begin
          tx_ack = 1'b1;
          chan_nxt = pbcd_pkg::CH_TX;
          src_nxt = tx_addr;
          left_nxt = tx_len;
          if (tx_len != pbcd_pkg::RST_CNT) state_nxt = pbcd_pkg::ST_WAIT_GRANT;
        end else if (go_r) begin
          chan_nxt = pbcd_pkg::CH_COPY;
          if (fs_r) begin
            stop = 1'b1;
          end else if (copy_bad) begin
            err_nxt = 1'b1;
            stop = 1'b1;
          end else begin
            src_nxt = reg_src_r;
            tgt_nxt = reg_tgt_r;
            left_nxt = reg_cnt_r;
            state_nxt = pbcd_pkg::ST_WAIT_GRANT;
          end
        end
      end
      pbcd_pkg::ST_WAIT_GRANT: begin
        if (chan_r == pbcd_pkg::CH_COPY && fs_r) begin
          stop = 1'b1;
        end else if (grant_r) begin
          state_nxt = (chan_r == pbcd_pkg::CH_RX) ? pbcd_pkg::ST_WRITE : pbcd_pkg::ST_READ;
        end
      end
      pbcd_pkg::ST_READ: begin
        if (cyc_done) begin
          byte_nxt = mem_rdata;
          src_nxt = step_addr(src_r, wrap_src, src_lo, src_hi);
          if (chan_r == pbcd_pkg::CH_TX) begin
            tx_data_nxt = mem_rdata;
            tx_valid_nxt = 1'b1;
            byte_end = 1'b1;
          end else begin
            state_nxt = pbcd_pkg::ST_WRITE;
          end
        end
      end
      pbcd_pkg::ST_WRITE: begin
        if (cyc_done) begin
          tgt_nxt = step_addr(tgt_r, wrap_tgt, tgt_lo, tgt_hi);
          rx_take = (chan_r == pbcd_pkg::CH_RX);
          byte_end = 1'b1;
        end
      end
      pbcd_pkg::ST_GAP: begin
        if (chan_r == pbcd_pkg::CH_COPY && fs_r) begin
          stop = 1'b1;
        end else if (gap_r <= 8'h01) begin
          state_nxt = (chan_r == pbcd_pkg::CH_RX) ? pbcd_pkg::ST_WRITE : pbcd_pkg::ST_READ;
        end else begin
          gap_nxt = gap_r - 8'h01;
        end
      end
      default: state_nxt = pbcd_pkg::ST_IDLE;
    endcase
    // Byte accounting and piece splitting
    if (byte_end) begin
      left_nxt = left_r - 16'h0001;
      chunk_nxt = chunk_r + 9'h001;
      state_nxt = (chan_r == pbcd_pkg::CH_RX) ? pbcd_pkg::ST_WRITE : pbcd_pkg::ST_READ;
      if (left_r == 16'h0001) begin
        finish = 1'b1;
      end else if (chan_r == pbcd_pkg::CH_COPY && fs_r) begin
        stop = 1'b1;
      end else if (chunk_r + 9'h001 == limit) begin
        chunk_nxt = 9'h000;
        gap_nxt = transfer_gap_register;
        if (transfer_gap_register != pbcd_pkg::RST_BYTE) state_nxt = pbcd_pkg::ST_GAP;
      end
    end
    // Completion or force stop releases the bus
    if (finish || stop) begin
      state_nxt = pbcd_pkg::ST_IDLE;
      grant_nxt = 1'b0;
      if (chan_r == pbcd_pkg::CH_COPY || stop) begin
        go_nxt = 1'b0;
        fs_nxt = 1'b0;
        sair_nxt = 1'b0;
        tait_nxt = 1'b0;
        if (finish) done_nxt = 1'b1;
      end
      rx_done = finish && chan_r == pbcd_pkg::CH_RX;
      tx_done = finish && chan_r == pbcd_pkg::CH_TX;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= pbcd_pkg::ST_IDLE; chan_r <= pbcd_pkg::CH_RX;
      src_r <= pbcd_pkg::RST_ADDR; tgt_r <= pbcd_pkg::RST_ADDR;
      left_r <= pbcd_pkg::RST_CNT; chunk_r <= 9'h000;
      gap_r <= pbcd_pkg::RST_BYTE; byte_r <= pbcd_pkg::RST_BYTE;
      grant_r <= 1'b0; done_r <= 1'b0; go_r <= 1'b0; fs_r <= 1'b0;
      err_r <= 1'b0; sair_r <= 1'b0; tait_r <= 1'b0; ei_r <= 1'b0;
      reg_src_r <= pbcd_pkg::RST_ADDR; reg_tgt_r <= pbcd_pkg::RST_ADDR;
      reg_cnt_r <= pbcd_pkg::RST_CNT; stage_r <= pbcd_pkg::RST_ADDR;
      index_r <= pbcd_pkg::RST_BYTE; wptr_r <= 2'h0; rptr_r <= 2'h0;
      rdata_r <= pbcd_pkg::RST_BYTE; tx_data_r <= pbcd_pkg::RST_BYTE;
      tx_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt; chan_r <= chan_nxt; src_r <= src_nxt; tgt_r <= tgt_nxt;
      left_r <= left_nxt; chunk_r <= chunk_nxt; gap_r <= gap_nxt; byte_r <= byte_nxt;
      grant_r <= grant_nxt; done_r <= done_nxt; go_r <= go_nxt; fs_r <= fs_nxt;
      err_r <= err_nxt; sair_r <= sair_nxt; tait_r <= tait_nxt; ei_r <= ei_nxt;
      reg_src_r <= reg_src_nxt; reg_tgt_r <= reg_tgt_nxt; reg_cnt_r <= reg_cnt_nxt;
      stage_r <= stage_nxt; index_r <= index_nxt; wptr_r <= wptr_nxt; rptr_r <= rptr_nxt;
      rdata_r <= rdata_nxt; tx_data_r <= tx_data_nxt; tx_valid_r <= tx_valid_nxt;
    end
  end

endmodule : pbcd_engine
`default_nettype wire

//--- pbcd_mem_model.sv
// External data memory model on the engine's far side
`timescale 1ns/100ps
`default_nettype none
module pbcd_mem_model (
  // Clock
  input wire logic ref_clk,
  // Memory port
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_r = 8'h00;
  // Store on write strobe, keep last read byte
  always @(posedge ref_clk) begin
    if (mem_we) mem[mem_addr[11:0]] <= mem_wdata;
    if (mem_re) last_r <= mem[mem_addr[11:0]];
  end
  // Released bus shows the inverse of the last byte
  assign mem_rdata = mem_re ? mem[mem_addr[11:0]] : ~last_r;
endmodule : pbcd_mem_model
`default_nettype wire

//--- pbcd_engine_props.sv
// Port checks for the packet and block copy engine
`timescale 1ns/100ps
`default_nettype none
module pbcd_engine_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Settings
  input wire logic [2:0] clock_stretch_control,
  input wire logic [7:0] transfer_gap_register,
  // Offload engine sides
  input wire logic rx_ack,
  input wire logic [15:0] rx_len,
  input wire logic rx_take,
  input wire logic rx_done,
  input wire logic tx_ack,
  input wire logic [15:0] tx_len,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_done,
  // Interrupt and memory
  input wire logic second_external_interrupt,
  input wire logic [23:0] mem_addr,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [7:0] mem_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Byte length, run length and idle length counters
  logic strobe, strobe_r, chg;
  logic [25:0] key, key_r;
  logic [3:0] cnt_r, cnt_nxt;
  logic [9:0] run_r, run_nxt;
  logic [15:0] idle_r, idle_nxt;
  always_comb begin
    strobe = mem_we | mem_re;
    key = {mem_we, mem_re, mem_addr};
    chg = strobe_r && (key != key_r);
    cnt_nxt = !strobe ? 4'h0 : (strobe_r && !chg) ? cnt_r + 4'h1 : 4'h1;
    run_nxt = (!second_external_interrupt || (strobe && !strobe_r)) ? 10'h000 : run_r + 10'(chg);
    idle_nxt = (strobe || !second_external_interrupt) ? 16'h0000 : idle_r + 16'h0001;
  end
  // Counter registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobe_r <= 1'b0;
      key_r <= 26'h0000000;
      cnt_r <= 4'h0;
      run_r <= 10'h000;
      idle_r <= 16'h0000;
    end else begin
      strobe_r <= strobe;
      key_r <= key;
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      idle_r <= idle_nxt;
    end
  end
  ////////////////////////////////////////
  // Request steps
  sequence rx_taken; rx_ack && rx_len != 16'h0000; endsequence
  sequence tx_taken; tx_ack && tx_len != 16'h0000; endsequence
  sequence stat_rd; sfr_rd && sfr_addr == pbcd_pkg::SFR_STATUS; endsequence
  // Checks
  irq_on_rx_a: assert property (rx_taken |=> second_external_interrupt)
    else $error("no interrupt after receive request");
  irq_on_tx_a: assert property (tx_taken |=> second_external_interrupt)
    else $error("no interrupt after transmit request");
  take_write_a: assert property (rx_take |-> mem_we)
    else $error("receive byte taken without a write");
  tx_read_a: assert property (tx_valid |-> $past(mem_re) && tx_data == $past(mem_rdata))
    else $error("transmit byte not the byte read");
  byte_time_a: assert property (chg |-> cnt_r == {1'b0, clock_stretch_control} + 4'h2)
    else $error("byte strobe length wrong");
  piece_size_a: assert property (|transfer_gap_register |-> run_r <= 10'h100)
    else $error("piece too long");
  gap_len_a: assert property (strobe && !strobe_r && run_r == 10'h100 |->
    idle_r == {8'h00, transfer_gap_register}) else $error("gap length wrong");
  strobe_irq_a: assert property (strobe |-> second_external_interrupt)
    else $error("strobe outside a granted transfer");
  done_drop_a: assert property (rx_done || tx_done |=> !second_external_interrupt)
    else $error("interrupt held after completion");
  index_read_a: assert property (sfr_rd && sfr_addr == pbcd_pkg::SFR_INDEX |=>
    sfr_rdata == 8'h00) else $error("index register readable");
  status_clear_a: assert property (stat_rd ##2 stat_rd |=> !sfr_rdata[0])
    else $error("done flag not cleared by read");
endmodule : pbcd_engine_chk
`default_nettype wire

//--- pbcd_engine_test.sv
// Self-checking bench for the packet and block copy engine
`timescale 1ns/100ps
`default_nettype none
module pbcd_engine_test;
  typedef struct {logic [23:0] s, t; logic [15:0] c; logic [7:0] f, e;} pbcd_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, rx_req = 1'b0, tx_req = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rx_data = 8'h00;
  logic [2:0] clock_stretch_control = 3'h1;
  logic [7:0] transfer_gap_register = 8'h03;
  logic [23:0] rx_ring_first = 24'h000400, rx_ring_last = 24'h00040f;
  logic [23:0] tx_ring_first = 24'h000800, tx_ring_last = 24'h0008ff;
  logic [23:0] rx_addr = 24'h000600, tx_addr = 24'h000800, tx_n = 24'h0, d, a;
  logic [15:0] rx_len = 16'h012c, tx_len = 16'h0104;
  wire [7:0] sfr_rdata, tx_data, mem_wdata, mem_rdata;
  wire rx_ack, rx_take, rx_done, tx_ack, tx_valid, tx_done, second_external_interrupt;
  wire mem_we, mem_re;
  wire [23:0] mem_addr;
  int miscompares = 0, num_checks = 0;
  logic [7:0] raddr [5] = '{8'h94, 8'h9a, 8'h9b, 8'h9c, 8'h50};
  pbcd_row_t rows [5] = '{'{24'h000100, 24'h000300, 16'h00c8, 8'h01, 8'h00},
    '{24'h000100, 24'h000300, 16'h0000, 8'h01, 8'h04}, '{24'h000100, 24'h000100, 16'h0004,
    8'h01, 8'h04}, '{24'h000100, 24'h000102, 16'h0004, 8'h01, 8'h04},
    '{24'h00040c, 24'h000500, 16'h0008, 8'h11, 8'h00}};
  ////////////////////////////////////////
  // Design and far side
  pbcd_engine pbcd_engine_inst (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .clock_stretch_control, .transfer_gap_register, .rx_ring_first, .rx_ring_last,
    .tx_ring_first, .tx_ring_last, .rx_req, .rx_addr, .rx_len, .rx_data, .rx_ack, .rx_take,
    .rx_done, .tx_req, .tx_addr, .tx_len, .tx_ack, .tx_data, .tx_valid, .tx_done,
    .second_external_interrupt, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
  pbcd_mem_model pbcd_mem_model_inst (.ref_clk, .mem_addr, .mem_wdata, .mem_we, .mem_re,
    .mem_rdata);
  // Clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Receive byte source steps on each taken byte
  always @(posedge ref_clk) begin
    rx_data <= rx_data + {7'h00, rx_take};
    if (tx_valid === 1'b1) begin
      chk(24'(tx_data), 24'(pat({4'h8, tx_n[7:0]})));
      tx_n <= tx_n + 24'h1;
    end
  end
  ////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] pat(input logic [11:0] x);
    return x[7:0] ^ {x[11:8], 4'h5};
  endfunction : pat
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic sfr_w(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge ref_clk);
    sfr_addr <= ad;
    sfr_wdata <= dt;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : sfr_w
  task automatic sfr_r(input logic [7:0] ad, output logic [23:0] v);
    @(posedge ref_clk);
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 v = {16'h0000, sfr_rdata};
  endtask : sfr_r
  task automatic wr_reg(input logic [7:0] idx, input logic [23:0] v, input int n);
    for (int i = 0; i < n; i++) sfr_w(pbcd_pkg::SFR_DATA, v[8*i +: 8]);
    sfr_w(pbcd_pkg::SFR_INDEX, idx);
  endtask : wr_reg
  task automatic rd_data(input int n, output logic [23:0] v);
    logic [23:0] b;
    v = 24'h000000;
    for (int i = 0; i < n; i++) begin
      sfr_r(pbcd_pkg::SFR_DATA, b);
      v[8*i +: 8] = b[7:0];
    end
  endtask : rd_data
  task automatic rd_cmd(output logic [23:0] v);
    wr_reg(pbcd_pkg::IDX_CMD, 24'h000000, 1);
    rd_data(1, v);
  endtask : rd_cmd
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("timeout at %0t", $time);
        end_sim;
      end
    end while ((sel == 0 ? second_external_interrupt : sel == 1 ? rx_ack : tx_ack) !== lvl);
  endtask : wait_sig
  task automatic grant_run;
    wait_sig(0, 1'b1, 20);
    sfr_w(pbcd_pkg::SFR_BUS_ARB, 8'h80);
    wait_sig(0, 1'b0, 5000);
  endtask : grant_run
  task automatic pkt(input logic tx);
    @(posedge ref_clk);
    tx_req <= tx;
    rx_req <= !tx;
    wait_sig(tx ? 2 : 1, 1'b1, 20);
    @(posedge ref_clk);
    rx_req <= 1'b0;
    tx_req <= 1'b0;
    grant_run;
  endtask : pkt
  ////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 4096; i++) pbcd_mem_model_inst.mem[i] = pat(i[11:0]);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (raddr[i]) begin
      sfr_r(raddr[i], d);
      chk(d, 24'h000000);
    end
    $display("reset test done");
    foreach (rows[r]) begin
      wr_reg(pbcd_pkg::IDX_SRC, rows[r].s, 3);
      rd_data(3, d);
      chk(d, rows[r].s);
      wr_reg(pbcd_pkg::IDX_TGT, rows[r].t, 3);
      wr_reg(pbcd_pkg::IDX_CNT, {8'h00, rows[r].c}, 2);
      wr_reg(pbcd_pkg::IDX_CMD, {16'h0000, rows[r].f}, 1);
      if (rows[r].e == 8'h00) grant_run;
      else repeat (3) @(posedge ref_clk);
      chk(24'(second_external_interrupt), 24'h000000);
      for (int i = 0; i < rows[r].c && rows[r].e == 8'h00; i++) begin
        a = rows[r].s + 24'(i);
        if (rows[r].f[4] && a > rx_ring_last) a = a - (rx_ring_last - rx_ring_first + 24'h1);
        chk(24'(pbcd_mem_model_inst.mem[rows[r].t[11:0] + i[11:0]]), 24'(pat(a[11:0])));
      end
      rd_cmd(d);
      chk(d, 24'(rows[r].e));
      sfr_r(pbcd_pkg::SFR_STATUS, d);
      chk(d, 24'(rows[r].e == 8'h00));
      sfr_r(pbcd_pkg::SFR_STATUS, d);
      chk(d, 24'h000000);
      $display("copy row %0d done", r);
    end
    // Abort while the copy waits for its grant
    wr_reg(pbcd_pkg::IDX_SRC, 24'h000100, 3);
    wr_reg(pbcd_pkg::IDX_CMD, 24'h000001, 1);
    wait_sig(0, 1'b1, 20);
    sfr_w(pbcd_pkg::SFR_INDEX, pbcd_pkg::IDX_ABORT);
    wait_sig(0, 1'b0, 50);
    rd_cmd(d);
    chk(d, 24'h000000);
    sfr_r(pbcd_pkg::SFR_STATUS, d);
    chk(d, 24'h000000);
    $display("abort test done");
    // Long receive packet into its ring
    @(posedge ref_clk);
    clock_stretch_control <= 3'h0;
    rx_ring_first <= 24'h000600;
    rx_ring_last <= 24'h0007ff;
    pkt(1'b0);
    for (int i = 0; i < 300; i++)
      chk(24'(pbcd_mem_model_inst.mem[12'h600 + i[11:0]]), 24'(i[7:0]));
    sfr_r(pbcd_pkg::SFR_BUS_ARB, d);
    chk(d, 24'h000000);
    $display("receive test done");
    pkt(1'b1);
    @(negedge ref_clk);
    chk(tx_n, 24'h000104);
    $display("transmit test done");
    end_sim;
  end
endmodule : pbcd_engine_test
bind pbcd_engine pbcd_engine_chk pbcd_engine_chk_inst (.ref_clk, .rst, .sfr_addr, .sfr_rd,
  .sfr_rdata, .clock_stretch_control, .transfer_gap_register, .rx_ack, .rx_len, .rx_take,
  .rx_done, .tx_ack, .tx_len, .tx_data, .tx_valid, .tx_done, .second_external_interrupt,
  .mem_addr, .mem_we, .mem_re, .mem_rdata);
`default_nettype wire
